// ==== rtl/host_port_slave.v ====
`timescale 1ns/1ps
`default_nettype none

// Serial host port: mode 0, MSB first, command byte then one data byte.
module host_port_slave (
   // Clock and reset.
   input wire sys_clk_i,
   input wire nrst_i,
   // Serial pins.
   input wire sck_i,
   input wire mosi_i,
   input wire cs_n_i,
   output wire miso_o,
   output wire miso_oe_o,
   // Register access.
   output wire [5:0] addr_o,
   output wire [7:0] wdata_o,
   output wire wr_stb_o,
   output wire rd_stb_o,
   input wire [7:0] rdata_i
);
`include "rx_serdes_regs.vh"

   reg [2:0] sck_s_q;
   reg [2:0] mosi_s_q;
   reg [2:0] cs_s_q;
   reg sck_f_q;
   reg mosi_f_q;
   reg cs_n_f_q;
   reg oe_q;
   reg [3:0] cnt_q;
   reg [7:0] rx_sh_q;
   reg [7:0] tx_sh_q;
   reg [7:0] cmd_q;
   reg miso_q;
   reg wr_q;
   reg rd_q;
   reg [7:0] wdata_q;

   wire rise = ~sck_f_q & sck_s_q[2] & (sck_s_q[1] == sck_s_q[2]);
   wire fall = sck_f_q & ~sck_s_q[2] & (sck_s_q[1] == sck_s_q[2]);
   wire [7:0] rx_n = {rx_sh_q[6:0], mosi_f_q};

   // Three-stage synchronisers; a change counts once stages two and three agree.
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sck_s_q <= 3'h0;
         mosi_s_q <= 3'h0;
         cs_s_q <= 3'h7;
         sck_f_q <= 1'b0;
         mosi_f_q <= 1'b0;
         cs_n_f_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         sck_s_q <= {sck_s_q[1:0], sck_i};
         mosi_s_q <= {mosi_s_q[1:0], mosi_i};
         cs_s_q <= {cs_s_q[1:0], cs_n_i};
         if (sck_s_q[1] == sck_s_q[2]) begin
            sck_f_q <= sck_s_q[2];
         end
         if (mosi_s_q[1] == mosi_s_q[2]) begin
            mosi_f_q <= mosi_s_q[2];
         end
         if (cs_s_q[1] == cs_s_q[2]) begin
            cs_n_f_q <= cs_s_q[2];
            oe_q <= ~cs_s_q[2];
         end
      end
   end

   // Shifts bits in, issues one read or write strobe per frame.
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= 4'h0;
         rx_sh_q <= 8'h00;
         tx_sh_q <= 8'h00;
         cmd_q <= 8'h00;
         miso_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         if (cs_n_f_q) begin
            cnt_q <= 4'h0;
            miso_q <= 1'b0;
         end else if (rise) begin
            rx_sh_q <= rx_n;
            if (cnt_q == 4'h7) begin
               cmd_q <= rx_n;
               rd_q <= ~rx_n[`CMD_WR_BIT];
            end
            if (cnt_q == 4'hF) begin
               wdata_q <= rx_n;
               wr_q <= cmd_q[`CMD_WR_BIT];
            end
            cnt_q <= cnt_q + 4'h1;
         end else if (fall) begin
            miso_q <= tx_sh_q[7];
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
         end
         if (rd_q) begin
            tx_sh_q <= rdata_i;
         end
      end
   end

   assign addr_o = cmd_q[5:0];
   assign wdata_o = wdata_q;
   assign wr_stb_o = wr_q;
   assign rd_stb_o = rd_q;
   assign miso_o = miso_q;
   // The enable has its own flop so the pin needs no gate after a register.
   assign miso_oe_o = oe_q;
endmodule

`default_nettype wire

// ==== rtl/rx_serdes_event_flags.v ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Enable bit 3 gates the channel A underflow interrupt.
// - Reading empty channel A data register is a channel A underflow.
// - Enable bit 2 gates the channel A overflow interrupt.
// - Loading channel A data while previous byte unread is an overflow.
// - Enable bit 1 gates the channel A end-of-frame interrupt.
// - End of frame after a valid bit once invalid run exceeds length.
// - Length zero ends the frame at the first invalid bit.
// - End-of-frame flag holds until a status read or leaving receive mode clears it.
// - Enable bit 0 gates the channel A full interrupt.
// - Full raised on every transfer: whole byte, or partial byte at EOF.
// - Status bit 7 set when a channel B byte is all valid.
// - Channel B valid flag never drives the interrupt.
// - Status bit 6 flags channel B overflow or underflow.
// - Status read clears the channel B flow violation flag.
// - Flags set regardless of interrupt enables.
// - Receive status reads zero outside receive mode.
// - Status register is read-only; writes change nothing.
// - End-of-frame length is bits 2:0 of serializer control.
// - Status bit 2 flags channel A flow violation, cleared by status read.
// - Status bit 1 flags channel A end of frame, cleared by status read.
// - Status bit 0 flags channel A data register filled.
module rx_serdes_event_flags (
   // Clock and reset.
   input wire sys_clk_i,
   input wire nrst_i,
   // Serial host port.
   input wire sck_i,
   input wire mosi_i,
   input wire cs_n_i,
   output wire miso_o,
   output wire miso_oe_o,
   // Receiver bit stream, index 0 is channel A, index 1 channel B.
   input wire rx_en_i,
   input wire [1:0] bit_tick_i,
   input wire [1:0] bit_valid_i,
   input wire [1:0] bit_data_i,
   // Interrupt.
   output reg irq_o
);
`include "rx_serdes_regs.vh"

   wire [5:0] addr;
   wire [7:0] wdata;
   wire wr_stb;
   wire rd_stb;
   reg [7:0] rdata;
   reg [7:0] ctrl_q;
   reg [7:0] en_q;
   wire [7:0] stat;
   wire [7:0] irq_src;
   wire [2:0] eof_len = ctrl_q[`CTRL_EOF_LEN_MSB:`CTRL_EOF_LEN_LSB];

   function hit;
      input [5:0] a;
      input [5:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire stat_rd = rd_stb & hit(addr, `ADDR_EVT_STAT);
   wire [1:0] data_rd;
   assign data_rd[0] = rd_stb & hit(addr, `ADDR_DATA_A);
   assign data_rd[1] = rd_stb & hit(addr, `ADDR_DATA_B);

   host_port_slave u_port (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .sck_i(sck_i),
      .mosi_i(mosi_i),
      .cs_n_i(cs_n_i),
      .miso_o(miso_o),
      .miso_oe_o(miso_oe_o),
      .addr_o(addr),
      .wdata_o(wdata),
      .wr_stb_o(wr_stb),
      .rd_stb_o(rd_stb),
      .rdata_i(rdata)
   );

   // Writable registers; the status address takes no write.
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= `RST_SERDES_CTRL;
         en_q <= `RST_EVT_EN;
      end else if (wr_stb) begin
         if (hit(addr, `ADDR_SERDES_CTRL)) begin
            ctrl_q <= wdata & `CTRL_WR_MASK;
         end
         if (hit(addr, `ADDR_EVT_EN)) begin
            en_q <= wdata;
         end
      end
   end

   // Per-channel receiver, data register and event flags.
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         reg started_q;
         reg [3:0] cnt_q;
         reg [3:0] run_q;
         reg [7:0] sh_q;
         reg allv_q;
         reg [7:0] data_q;
         reg unread_q;
         reg valid_q;
         reg full_q;
         reg eof_q;
         reg ovf_q;
         reg unf_q;
         reg [7:0] sh_n;
         wire tick = bit_tick_i[c];
         wire vld = bit_valid_i[c];
         // Length zero gives end of frame on the first invalid bit.
         wire eof_ev = tick & started_q & ~vld &
            (run_q >= {1'b0, eof_len});
         wire take = tick & (started_q | vld) & ~eof_ev;
         wire byte_done = take & (cnt_q[2:0] == `LAST_BIT);
         wire xfer = byte_done | (eof_ev & (cnt_q != 4'h0));
         wire [7:0] xdata = byte_done ? sh_n : sh_q;

         always @* begin
            sh_n = sh_q;
            sh_n[cnt_q[2:0]] = bit_data_i[c];
         end

         always @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               started_q <= 1'b0;
               cnt_q <= 4'h0;
               run_q <= 4'h0;
               sh_q <= 8'h00;
               allv_q <= 1'b1;
               data_q <= 8'h00;
               unread_q <= 1'b0;
               valid_q <= 1'b0;
               full_q <= 1'b0;
               eof_q <= 1'b0;
               ovf_q <= 1'b0;
               unf_q <= 1'b0;
            end else if (!rx_en_i) begin
               started_q <= 1'b0;
               cnt_q <= 4'h0;
               run_q <= 4'h0;
               sh_q <= 8'h00;
               allv_q <= 1'b1;
               unread_q <= 1'b0;
               valid_q <= 1'b0;
               full_q <= 1'b0;
               eof_q <= 1'b0;
               ovf_q <= 1'b0;
               unf_q <= 1'b0;
            end else begin
               if (eof_ev) begin
                  started_q <= 1'b0;
                  cnt_q <= 4'h0;
                  run_q <= 4'h0;
                  sh_q <= 8'h00;
                  allv_q <= 1'b1;
               end else if (take) begin
                  started_q <= 1'b1;
                  run_q <= vld ? 4'h0 : run_q + 4'h1;
                  if (byte_done) begin
                     cnt_q <= 4'h0;
                     sh_q <= 8'h00;
                     allv_q <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                     sh_q <= sh_n;
                     allv_q <= allv_q & vld;
                  end
               end
               if (xfer) begin
                  data_q <= xdata;
                  valid_q <= byte_done & allv_q & vld;
               end
               // Set wins over the clearing read in every flag below.
               unread_q <= xfer | (unread_q & ~data_rd[c]);
               full_q <= xfer | (full_q & ~stat_rd);
               eof_q <= eof_ev | (eof_q & ~stat_rd);
               ovf_q <= (xfer & unread_q & ~data_rd[c]) |
                  (ovf_q & ~stat_rd);
               unf_q <= (data_rd[c] & ~unread_q) |
                  (unf_q & ~stat_rd);
            end
         end

         // Flags are raised whatever the enables hold.
         assign stat[4*c+`ST_FULL] = full_q;
         assign stat[4*c+`ST_EOF] = eof_q;
         assign stat[4*c+`ST_FLOW] = ovf_q | unf_q;
         assign stat[4*c+`ST_VALID] = valid_q;
         assign irq_src[4*c+`EN_FULL_A] = full_q;
         assign irq_src[4*c+`EN_EOF_A] = eof_q;
         assign irq_src[4*c+`EN_OVF_A] = ovf_q;
         assign irq_src[4*c+`EN_UNF_A] = unf_q;
      end
   endgenerate

   // Read data for the host port.
   always @* begin
      rdata = 8'h00;
      if (hit(addr, `ADDR_SERDES_CTRL)) begin
         rdata = ctrl_q;
      end else if (hit(addr, `ADDR_EVT_EN)) begin
         rdata = en_q;
      end else if (hit(addr, `ADDR_EVT_STAT)) begin
         rdata = rx_en_i ? stat : `RST_EVT_STAT;
      end else if (hit(addr, `ADDR_DATA_A)) begin
         rdata = g_ch[0].data_q;
      end else if (hit(addr, `ADDR_DATA_B)) begin
         rdata = g_ch[1].data_q;
      end
   end

   // Interrupt from enabled sources; valid flags are not sources.
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_src & en_q);
      end
   end
endmodule

`default_nettype wire

// ==== rtl/rx_serdes_regs.vh ====
`ifndef RX_SERDES_REGS_VH
`define RX_SERDES_REGS_VH

// Register addresses on the serial host port.
`define ADDR_SERDES_CTRL 6'h06
`define ADDR_EVT_EN 6'h07
`define ADDR_EVT_STAT 6'h08
`define ADDR_DATA_A 6'h09
`define ADDR_DATA_B 6'h0B

// Reset values.
`define RST_SERDES_CTRL 8'h00
`define RST_EVT_EN 8'h00
`define RST_EVT_STAT 8'h00

// Serializer control fields.
`define CTRL_EOF_LEN_MSB 2
`define CTRL_EOF_LEN_LSB 0
`define CTRL_WR_MASK 8'h0F

// Enable register fields, channel A.
`define EN_FULL_A 0
`define EN_EOF_A 1
`define EN_OVF_A 2
`define EN_UNF_A 3
// Channel B fields sit four bits higher.
`define EN_CH_STRIDE 4

// Status register fields, channel A; channel B sits four bits higher.
`define ST_FULL 0
`define ST_EOF 1
`define ST_FLOW 2
`define ST_VALID 3

// Host frame: first byte holds the write flag and the address.
`define CMD_WR_BIT 7
`define BITS_PER_BYTE 4'h8
`define LAST_BIT 3'h7

`endif

// ==== sim/rx_serdes_event_flags_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_serdes_event_flags_asserts (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Host port.
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic cs_n_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   // Receiver and interrupt.
   input wire logic rx_en_i,
   input wire logic [1:0] bit_tick_i,
   input wire logic [1:0] bit_valid_i,
   input wire logic [1:0] bit_data_i,
   input wire logic irq_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence quiet_s;
      (cs_n_i && rx_en_i)[*8];
   endsequence
   chk_rst_clear: assert property ($rose(nrst_i) |-> !irq_o && !miso_oe_o)
      else $error("outputs not clear after reset");
   chk_rx_off: assert property ((!rx_en_i)[*3] |-> !irq_o)
      else $error("interrupt outside receive mode");
   chk_irq_cause: assert property (quiet_s ##1 $rose(irq_o) |->
      $past(bit_tick_i, 2) != 2'h0)
      else $error("interrupt rose without a bit tick");
   chk_irq_hold: assert property (quiet_s |-> !$fell(irq_o))
      else $error("interrupt dropped without a status read");
   chk_oe_rise: assert property ($fell(cs_n_i) |-> ##[1:6] miso_oe_o)
      else $error("output enable late after select");
   chk_oe_fall: assert property ($rose(cs_n_i) |-> ##[1:6] !miso_oe_o)
      else $error("output enable held after deselect");
   chk_oe_hold: assert property ((!cs_n_i)[*8] |-> miso_oe_o)
      else $error("output enable low while selected");
   chk_oe_idle: assert property (cs_n_i[*8] |-> !miso_oe_o)
      else $error("output enable high while idle");
endmodule
bind rx_serdes_event_flags rx_serdes_event_flags_asserts chk (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sck_i(sck_i), .mosi_i(mosi_i),
   .cs_n_i(cs_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
   .rx_en_i(rx_en_i), .bit_tick_i(bit_tick_i), .bit_valid_i(bit_valid_i),
   .bit_data_i(bit_data_i), .irq_o(irq_o));
`default_nettype wire

// ==== sim/rx_serdes_event_flags_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_serdes_event_flags_bench;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic rx_en_i = 1'b0;
   logic sck, mosi, cs_n, miso, miso_oe, irq;
   logic [1:0] tick = 2'h0, vld = 2'h0, dat = 2'h0;
   logic [1:0] full, eof, ovf, unf, vb;
   logic [7:0] sh[2], dreg[2], en, rd;
   int fail_count = 0, n_checks = 0, len;
   int st[2], n[2], run[2], unr[2], allv[2];
   initial begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   rx_serdes_event_flags uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .sck_i(sck), .mosi_i(mosi), .cs_n_i(cs_n), .miso_o(miso),
      .miso_oe_o(miso_oe), .rx_en_i(rx_en_i), .bit_tick_i(tick),
      .bit_valid_i(vld), .bit_data_i(dat), .irq_o(irq));
   spi_host_model host (.clk_i(sys_clk_i), .miso_i(miso), .sck_o(sck),
      .mosi_o(mosi), .cs_n_o(cs_n));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic irq_chk();
      check({7'h00, irq}, {7'h00, |({unf[1], ovf[1], eof[1], full[1],
         unf[0], ovf[0], eof[0], full[0]} & en)});
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host.xfer({2'h2, a, d}, rd);
   endtask
   task automatic rd_stat();
      host.xfer({2'h0, 6'h08, 8'h00}, rd);
      check(rd, rx_en_i ? {vb[1], ovf[1] | unf[1], eof[1], full[1], vb[0],
         ovf[0] | unf[0], eof[0], full[0]} : 8'h00);
      {full, eof, ovf, unf} = 8'h00;
      irq_chk();
   endtask
   task automatic rd_data(input int c);
      host.xfer({2'h0, ((c != 0) ? 6'h0B : 6'h09), 8'h00}, rd);
      check(rd, dreg[c]);
      if (unr[c] == 0) unf[c] = 1'b1;
      unr[c] = 0;
      irq_chk();
   endtask
   task automatic load(input int c, input logic v);
      if (unr[c]) ovf[c] = 1'b1;
      unr[c] = 1;
      full[c] = 1'b1;
      vb[c] = v;
      dreg[c] = sh[c];
      sh[c] = 8'h00;
      n[c] = 0;
   endtask
   task automatic bit_in(input int c, input logic v, input logic d);
      @(posedge sys_clk_i);
      tick[c] <= 1'b1;
      vld[c] <= v;
      dat[c] <= d;
      @(posedge sys_clk_i);
      tick <= 2'h0;
      vld[c] <= ~v;
      dat[c] <= ~d;
      if (rx_en_i && (v || st[c] != 0)) begin
         if (!v && run[c] >= len) begin
            eof[c] = 1'b1;
            if (n[c] > 0) load(c, 1'b0);
            st[c] = 0;
            n[c] = 0;
            run[c] = 0;
         end else begin
            st[c] = 1;
            sh[c][n[c]] = d;
            allv[c] = (n[c] == 0) ? int'(v) : allv[c] & int'(v);
            run[c] = v ? 0 : run[c] + 1;
            n[c]++;
            if (n[c] == 8) load(c, allv[c] != 0);
         end
      end
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      irq_chk();
   endtask
   initial begin
      repeat (50000) @(posedge sys_clk_i);
      fail_count++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h49C6));
      en = 8'h00;
      len = 0;
      {full, eof, ovf, unf, vb} = 10'h000;
      st = '{0, 0};
      n = '{0, 0};
      run = '{0, 0};
      unr = '{0, 0};
      sh = '{8'h00, 8'h00};
      dreg = '{8'h00, 8'h00};
      repeat (10) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rx_en_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      host.xfer({2'h0, 6'h07, 8'h00}, rd);
      check(rd, 8'h00);
      rd_stat();
      host.xfer({2'h0, 6'h3F, 8'h00}, rd);
      check(rd, 8'h00);
      for (int k = 0; k < 3; k++) begin
         len = (k == 0) ? 0 : (k == 1) ? 7 : $urandom_range(1, 6);
         wr(6'h06, 8'(len));
         host.xfer({2'h0, 6'h06, 8'h00}, rd);
         check(rd, 8'(len));
         en = 8'($urandom);
         wr(6'h07, en);
         irq_chk();
         host.xfer({2'h0, 6'h07, 8'h00}, rd);
         check(rd, en);
         rd_data(0);
         rd_data(1);
         for (int i = 0; i < 48; i++) begin
            bit_in($urandom_range(0, 1), $urandom_range(0, 3) > 0,
               1'($urandom));
            if (i % 16 == 15) begin
               rd_data(0);
               rd_data(1);
               wr(6'h08, 8'hFF);
               rd_stat();
            end
         end
         for (int i = 0; i <= len; i++) bit_in(0, 1'b0, 1'b0);
         rd_stat();
      end
      bit_in(0, 1'b1, 1'b1);
      @(posedge sys_clk_i);
      rx_en_i <= 1'b0;
      {full, eof, ovf, unf, vb} = 10'h000;
      bit_in(1, 1'b1, 1'b1);
      rd_stat();
      stop_test();
   end
endmodule
`default_nettype wire

// ==== sim/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk_i,
   input wire logic miso_i,
   output logic sck_o,
   output logic mosi_o,
   output logic cs_n_o
);
   initial begin
      sck_o = 1'b0;
      mosi_o = 1'b1;
      cs_n_o = 1'b1;
   end
   // One frame: command byte then data byte, MSB first, mode 0.
   task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o <= tx[i];
         repeat (8) @(posedge clk_i);
         sck_o <= 1'b1;
         if (i < 8) rx = {rx[6:0], miso_i};
         repeat (8) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      repeat (10) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire
